// ### hdl/wls_supervisor.sv
/*
 Eight-channel level supervisor with hysteresis, APB register slave.
 Assumes weight samples and update strobe are synchronous to pclk and
 signed; pready is always high, unmapped addresses read zero with pslverr.
*/
module wls_supervisor #(
    parameter int CHANNELS = wls_pkg::WLS_CHANNELS,
    parameter int WW       = wls_pkg::WLS_WW
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic signed [WW-1:0] net_weight,
    input  wire logic signed [WW-1:0] gross_weight,
    input  wire logic signed [WW-1:0] flow_rate,
    input  wire logic                weight_update,
    output logic      [CHANNELS-1:0] level_status,
    output logic      [CHANNELS-1:0] int_out,
    output logic      [CHANNELS-1:0] ext_out
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic signed [WW-1:0] wls_abs(input logic signed [WW-1:0] v);
        wls_abs = v[WW-1] ? -v : v;
    endfunction

    // Clamp a written level to the signed +/-99999 range
    function automatic logic signed [WW-1:0] wls_clamp(input logic signed [WW-1:0] v);
        logic signed [WW-1:0] lim;
        lim = WW'(wls_pkg::WLS_LEVEL_MAX);
        if (v > lim)
            wls_clamp = lim;
        else if (v < -lim)
            wls_clamp = -lim;
        else
            wls_clamp = v;
    endfunction

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic        [1:0]           ctrl_reg,   ctrl_next;
    logic        [5:0]           cfg_reg     [CHANNELS];
    logic        [5:0]           cfg_next    [CHANNELS];
    logic signed [WW-1:0]        level_reg   [CHANNELS];
    logic signed [WW-1:0]        level_next  [CHANNELS];
    logic signed [WW-1:0]        hyst_reg    [CHANNELS];
    logic signed [WW-1:0]        hyst_next   [CHANNELS];
    logic        [31:0]          prdata_reg, prdata_next;
    logic                        pslverr_reg, pslverr_next;
    logic        [CHANNELS-1:0]  stat_reg,   stat_next;
    logic        [CHANNELS-1:0]  int_reg,    int_next;
    logic        [CHANNELS-1:0]  ext_reg,    ext_next;

    logic                        acc;
    logic                        chsel;
    logic        [11:0]          choff;
    int unsigned                 chidx;
    logic        [3:0]           sub;

    assign acc    = psel & penable;
    assign pready = 1'b1;
    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg;
    assign level_status = stat_reg;
    assign int_out = int_reg;
    assign ext_out = ext_reg;

    always_comb
    begin
        choff = paddr - wls_pkg::WLS_OFS_CH0;
        chidx = 32'(choff >> 4);
        sub   = choff[3:0];
        chsel = (paddr >= wls_pkg::WLS_OFS_CH0) && (chidx < CHANNELS) && (paddr[1:0] == 2'b00);
    end

    // ------------------------------------------------------------
    // APB register file
    // ------------------------------------------------------------
    always_comb
    begin
        ctrl_next    = ctrl_reg;
        cfg_next     = cfg_reg;
        level_next   = level_reg;
        hyst_next    = hyst_reg;
        prdata_next  = prdata_reg;
        pslverr_next = 1'b0;
        if (psel && !penable)
        begin
            prdata_next = wls_pkg::WLS_RST_WORD;
            if (paddr == wls_pkg::WLS_OFS_CTRL)
                prdata_next = {30'h0, ctrl_reg};
            else if (paddr == wls_pkg::WLS_OFS_STATUS)
                prdata_next = {{(32-CHANNELS){1'b0}}, stat_reg};
            else if (paddr == wls_pkg::WLS_OFS_OUTS)
                prdata_next = {{(32-2*CHANNELS){1'b0}}, ext_reg, int_reg};
            else if (chsel && sub == wls_pkg::WLS_SUB_CFG)
                prdata_next = {26'h0, cfg_reg[chidx]};
            else if (chsel && sub == wls_pkg::WLS_SUB_LEVEL)
                prdata_next = 32'(level_reg[chidx]);
            else if (chsel && sub == wls_pkg::WLS_SUB_HYST)
                prdata_next = 32'(hyst_reg[chidx]);
        end
        if (acc)
        begin
            pslverr_next = !((paddr == wls_pkg::WLS_OFS_CTRL) || (paddr == wls_pkg::WLS_OFS_STATUS)
                          || (paddr == wls_pkg::WLS_OFS_OUTS)
                          || (chsel && (sub == wls_pkg::WLS_SUB_CFG || sub == wls_pkg::WLS_SUB_LEVEL
                                        || sub == wls_pkg::WLS_SUB_HYST)));
            if (pwrite)
            begin
                if (paddr == wls_pkg::WLS_OFS_CTRL)
                    ctrl_next = pwdata[1:0];
                else if (chsel && sub == wls_pkg::WLS_SUB_CFG)
                begin
                    cfg_next[chidx] = pwdata[5:0];
                    // offset source only above channel 1
                    if (chidx == 0 && pwdata[3:0] == wls_pkg::WLS_SRC_OFFSET1)
                        cfg_next[chidx][3:0] = wls_pkg::WLS_SRC_OFF;
                    if (pwdata[3:0] > wls_pkg::WLS_SRC_OFFSET1)
                        cfg_next[chidx][3:0] = wls_pkg::WLS_SRC_OFF;
                end
                // levels held in signed 99999 range
                else if (chsel && sub == wls_pkg::WLS_SUB_LEVEL)
                    level_next[chidx] = wls_clamp(WW'(signed'(pwdata)));
                else if (chsel && sub == wls_pkg::WLS_SUB_HYST)
                    hyst_next[chidx] = WW'(signed'(pwdata));
            end
        end
    end

    // ------------------------------------------------------------
    // Level evaluation
    // ------------------------------------------------------------
    always_comb
    begin
        logic        [3:0]    src;
        logic        [3:0]    s1;
        logic signed [WW-1:0] sig;
        logic signed [WW-1:0] thr;
        logic signed [WW-1:0] hi;
        logic signed [WW-1:0] lo;
        logic                 en;
        logic                 act;
        src = '0;
        s1 = '0;
        sig = '0;
        thr = '0;
        hi = '0;
        lo = '0;
        en = 1'b0;
        act = 1'b0;
        stat_next = stat_reg;
        int_next  = int_reg;
        ext_next  = ext_reg;
        for (int i = 0; i < CHANNELS; i++)
        begin
            src = cfg_reg[i][3:0];
            thr = level_reg[i];
            // follow channel 1 signal, level offset
            if (src == wls_pkg::WLS_SRC_OFFSET1)
            begin
                src = cfg_reg[0][3:0];
                thr = level_reg[0] + level_reg[i];
            end
            s1 = (src >= wls_pkg::WLS_SRC_ABS_NET) ? 4'(src - 4'h4) : src;
            unique case (s1)
                wls_pkg::WLS_SRC_NET:   sig = net_weight;
                wls_pkg::WLS_SRC_GROSS: sig = gross_weight;
                wls_pkg::WLS_SRC_DISP:  sig = ctrl_reg[wls_pkg::WLS_CTRL_NET] ? net_weight : gross_weight;
                wls_pkg::WLS_SRC_FLOW:  sig = flow_rate;
                default:                sig = '0;
            endcase
            if (src >= wls_pkg::WLS_SRC_ABS_NET && src <= wls_pkg::WLS_SRC_ABS_FLOW)
                sig = wls_abs(sig);
            en = (src != wls_pkg::WLS_SRC_OFF) && (src <= wls_pkg::WLS_SRC_ABS_FLOW)
                 && !(s1 == wls_pkg::WLS_SRC_FLOW && !ctrl_reg[wls_pkg::WLS_CTRL_FLOW]);
            // one threshold at level, other shifted by width
            hi = hyst_reg[i][WW-1] ? thr : thr + hyst_reg[i];
            lo = hyst_reg[i][WW-1] ? thr + hyst_reg[i] : thr;
            if (!en)
                stat_next[i] = 1'b0;
            else if (weight_update)
            begin
                if (sig > hi)
                    stat_next[i] = 1'b1;
                else if (sig < lo)
                    stat_next[i] = 1'b0;
            end
            act = en && (cfg_reg[i][wls_pkg::WLS_CFG_SENSE] ? !stat_next[i] : stat_next[i]);
            // route to internal or expansion output
            int_next[i] = act && !cfg_reg[i][wls_pkg::WLS_CFG_ROUTE];
            ext_next[i] = act && cfg_reg[i][wls_pkg::WLS_CFG_ROUTE];
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // one state set per channel
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg    <= '0;
            prdata_reg  <= '0;
            pslverr_reg <= 1'b0;
            stat_reg    <= '0;
            int_reg     <= '0;
            ext_reg     <= '0;
            for (int i = 0; i < CHANNELS; i++)
            begin
                cfg_reg[i]   <= '0;
                level_reg[i] <= '0;
                hyst_reg[i]  <= '0;
            end
        end
        else
        begin
            ctrl_reg    <= ctrl_next;
            prdata_reg  <= prdata_next;
            pslverr_reg <= pslverr_next;
            stat_reg    <= stat_next;
            int_reg     <= int_next;
            ext_reg     <= ext_next;
            cfg_reg     <= cfg_next;
            level_reg   <= level_next;
            hyst_reg    <= hyst_next;
        end
    end
endmodule

// ### common/wls_pkg.sv
/*
 Constants for the eight-channel weight level supervisor: register map,
 field layout, source codes and widths.
 Assumes an APB master on the instrument core clock and reset.
*/
package wls_pkg;
    localparam int          WLS_CHANNELS   = 8;
    localparam int          WLS_WW         = 32;
    localparam int          WLS_LEVEL_MAX  = 99999;
    localparam int          WLS_LEVEL_W    = 18;

    // Register byte offsets; channel block stride is WLS_CH_STRIDE
    localparam logic [11:0] WLS_OFS_CTRL   = 12'h000;
    localparam logic [11:0] WLS_OFS_STATUS = 12'h004;
    localparam logic [11:0] WLS_OFS_OUTS   = 12'h008;
    localparam logic [11:0] WLS_OFS_CH0    = 12'h040;
    localparam logic [11:0] WLS_CH_STRIDE  = 12'h010;
    localparam logic [3:0]  WLS_SUB_CFG    = 4'h0;
    localparam logic [3:0]  WLS_SUB_LEVEL  = 4'h4;
    localparam logic [3:0]  WLS_SUB_HYST   = 4'h8;

    // CTRL fields
    localparam int          WLS_CTRL_FLOW  = 0;
    localparam int          WLS_CTRL_NET   = 1;
    // Channel config fields
    localparam int          WLS_CFG_SRC_LO = 0;
    localparam int          WLS_CFG_SRC_W  = 4;
    localparam int          WLS_CFG_SENSE  = 4;
    localparam int          WLS_CFG_ROUTE  = 5;

    localparam logic [3:0]  WLS_SRC_OFF      = 4'h0;
    localparam logic [3:0]  WLS_SRC_NET      = 4'h1;
    localparam logic [3:0]  WLS_SRC_GROSS    = 4'h2;
    localparam logic [3:0]  WLS_SRC_DISP     = 4'h3;
    localparam logic [3:0]  WLS_SRC_FLOW     = 4'h4;
    localparam logic [3:0]  WLS_SRC_ABS_NET  = 4'h5;
    localparam logic [3:0]  WLS_SRC_ABS_GRS  = 4'h6;
    localparam logic [3:0]  WLS_SRC_ABS_DISP = 4'h7;
    localparam logic [3:0]  WLS_SRC_ABS_FLOW = 4'h8;
    localparam logic [3:0]  WLS_SRC_OFFSET1  = 4'h9;

    localparam logic [31:0] WLS_RST_WORD     = 32'h0000_0000;
endpackage

// ### test/wls_sup_asserts.sv
/*
 Port checker for the weight level supervisor, bound to its top module.
 Assumes one clock pclk and the asynchronous active-low reset presetn.
*/
module wls_sup_asserts #(
    parameter int CHANNELS = 8,
    parameter int WW       = 32
) (
    input wire logic                pclk,
    input wire logic                presetn,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [11:0]         paddr,
    input wire logic [31:0]         prdata,
    input wire logic                pslverr,
    input wire logic                weight_update,
    input wire logic [CHANNELS-1:0] level_status,
    input wire logic [CHANNELS-1:0] int_out,
    input wire logic [CHANNELS-1:0] ext_out
);
    logic wr;
    logic rd;
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    chk_route_excl: assert property ((int_out & ext_out) == '0)
        else $error("output driven on both routes");
    chk_status_cause: assert property (!weight_update && !wr && !$past(wr) |=> $stable(level_status))
        else $error("status moved without update");
    chk_outs_cause: assert property ($changed({int_out, ext_out}) |->
        $past(weight_update) || $past(weight_update, 2) || $past(wr) || $past(wr, 2))
        else $error("output moved without cause");
    chk_status_read: assert property (rd && paddr == wls_pkg::WLS_OFS_STATUS |->
        prdata[CHANNELS-1:0] == $past(level_status)) else $error("status read differs");
    chk_outs_read: assert property (rd && paddr == wls_pkg::WLS_OFS_OUTS |->
        prdata[15:0] == {$past(ext_out), $past(int_out)}) else $error("outputs read differs");
    chk_level_range: assert property (rd && paddr >= wls_pkg::WLS_OFS_CH0 && paddr[3:0] == 4'h4 |->
        $signed(prdata) <= wls_pkg::WLS_LEVEL_MAX && $signed(prdata) >= -wls_pkg::WLS_LEVEL_MAX)
        else $error("level out of range");
    chk_ninth_zero: assert property (rd && paddr == 12'h0c0 |-> prdata == '0)
        else $error("absent channel reads nonzero");
    chk_ninth_err: assert property (psel && penable && paddr == 12'h0c0 |=> pslverr)
        else $error("absent channel gave no error");
endmodule

bind wls_supervisor wls_sup_asserts #(.CHANNELS(CHANNELS), .WW(WW)) chk_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
    .weight_update(weight_update), .level_status(level_status), .int_out(int_out), .ext_out(ext_out));

// ### test/wls_equipment.sv
/*
 Stand-in for equipment wired to the level outputs.
 Assumes outputs are active high and synchronous to pclk.
*/
module wls_equipment #(
    parameter int CHANNELS = 8
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic [CHANNELS-1:0] int_out,
    input  wire logic [CHANNELS-1:0] ext_out,
    output logic      [CHANNELS-1:0] driven_reg
);
    logic [CHANNELS-1:0] driven_next;
    always_comb driven_next = int_out | ext_out;
    // Relays see a line one clock late
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            driven_reg <= '0;
        else
            driven_reg <= driven_next;
endmodule

// ### test/testbench.sv
/*
 Self-checking bench for the weight level supervisor.
 Assumes the checker is bound and the equipment model watches the outputs.
*/
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic               pclk, presetn, psel, penable, pwrite, weight_update, pready, pslverr, err;
    logic        [11:0] paddr;
    logic        [31:0] pwdata, prdata, rd;
    logic signed [31:0] net_w, gross_w, flow_w;
    logic        [7:0]  level_status, int_out, ext_out, driven;
    int                 num_errors = 0;
    int                 n_tests = 0;
    wls_supervisor dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .net_weight(net_w), .gross_weight(gross_w), .flow_rate(flow_w), .weight_update(weight_update),
        .level_status(level_status), .int_out(int_out), .ext_out(ext_out));
    wls_equipment eq_u (.pclk(pclk), .presetn(presetn), .int_out(int_out), .ext_out(ext_out),
        .driven_reg(driven));
    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        err = pslverr;
    endtask
    task automatic cfg(input int n, input logic [31:0] c, input logic [31:0] lv, input logic [31:0] hy);
        apb(1'b1, 12'h040 + 12'(16 * n), c);
        apb(1'b1, 12'h044 + 12'(16 * n), lv);
        apb(1'b1, 12'h048 + 12'(16 * n), hy);
    endtask
    // One weight tick, then every view of the resulting status except the OUTS register
    task automatic upd(input logic [31:0] n, g, f, input logic [7:0] st, below);
        logic [7:0] ei;
        ei = (st & 8'h2d) | (~st & below);
        @(posedge pclk);
        net_w <= n;
        gross_w <= g;
        flow_w <= f;
        weight_update <= 1'b1;
        @(posedge pclk);
        weight_update <= 1'b0;
        #1;
        check(32'(level_status), 32'(st));
        check(32'(int_out), 32'(ei));
        check(32'(ext_out), 32'(st & 8'h10));
        apb(1'b0, wls_pkg::WLS_OFS_STATUS, 32'h0);
        check(rd, 32'(st));
        check(32'(driven), 32'(ei | (st & 8'h10)));
    endtask
    task automatic t_reset();
        apb(1'b0, wls_pkg::WLS_OFS_CTRL, 32'h0);
        check(rd, wls_pkg::WLS_RST_WORD);
        upd(32'h64, 32'h64, 32'h64, 8'h00, 8'h00);
    endtask
    task automatic t_hyst();
        cfg(0, 32'(wls_pkg::WLS_SRC_NET), 32'h64, 32'ha);
        cfg(1, 32'(wls_pkg::WLS_SRC_GROSS) | 32'h10, 32'h64, -32'ha);
        cfg(2, 32'(wls_pkg::WLS_SRC_DISP), 32'h64, 32'h0);
        cfg(3, 32'(wls_pkg::WLS_SRC_OFFSET1), 32'h32, 32'h0);
        cfg(4, 32'(wls_pkg::WLS_SRC_ABS_NET) | 32'h20, 32'h32, 32'h0);
        cfg(5, 32'(wls_pkg::WLS_SRC_FLOW), 32'h0, 32'h0);
        upd(32'h69, 32'h69, 32'h1f4, 8'h16, 8'h02);
        upd(32'h70, 32'h5f, 32'h1f4, 8'h13, 8'h02);
    endtask
    task automatic t_abs();
        upd(-32'ha0, 32'h59, 32'h1f4, 8'h10, 8'h02);
    endtask
    task automatic t_disp_flow();
        apb(1'b1, wls_pkg::WLS_OFS_CTRL, 32'h3);
        upd(32'ha0, 32'h0, 32'h1f4, 8'h3d, 8'h02);
    endtask
    task automatic t_clamp();
        // Last channel's level word; channel 7 sits at 0x040 + 7 * 0x010
        apb(1'b1, 12'h0b4, 32'h30d40);
        apb(1'b0, 12'h0b4, 32'h0);
        check(rd, 32'(wls_pkg::WLS_LEVEL_MAX));
        apb(1'b1, 12'h0b4, -32'h30d40);
        apb(1'b0, 12'h0b4, 32'h0);
        check(rd, -32'(wls_pkg::WLS_LEVEL_MAX));
        apb(1'b0, 12'h0c0, 32'h0);
        check(rd, 32'h0);
        check(32'(err), 32'h1);
    endtask
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (5000) @(posedge pclk);
        num_errors++;
        conclude();
    end
    initial
    begin
        {presetn, psel, penable, pwrite, weight_update} = 5'h0;
        {paddr, pwdata, net_w, gross_w, flow_w} = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_hyst();
        t_abs();
        t_disp_flow();
        t_clamp();
        conclude();
    end
endmodule
